// ==== design/psc_params.svh ====
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

// Register indices; the byte address is four times the index
`define PSC_IDX_SIGN       16'hE617
`define PSC_IDX_CONFIG     16'hE618
`define PSC_IDX_SOURCE     16'hE6F0
`define PSC_IDX_PTYPE      16'hE6F1
`define PSC_ADDR_W         18

// Configuration fields and reset value
`define PSC_CFG_PHASE_INTEGRATOR_ENABLE      0
`define PSC_CFG_RSV1       1
`define PSC_CFG_PIN2       2
`define PSC_CFG_SWAP       3
`define PSC_CFG_VGND       4
`define PSC_CFG_IGND       5
`define PSC_CFG_FCAP       6
`define PSC_CFG_SOFTWARE_RESET_TRIGGER      7
`define PSC_CFG_VA_LSB     8
`define PSC_CFG_VB_LSB     10
`define PSC_CFG_RESET      16'h0002

// Sign source fields and reset value
`define PSC_SRC_APSEL      0
`define PSC_SRC_T1_LSB     1
`define PSC_SRC_T2_LSB     4
`define PSC_SRC_T3_LSB     7
`define PSC_SRC_NINT       10
`define PSC_SRC_RESET      16'h03FE

// Pulse power type fields and reset value
`define PSC_PT1_LSB        0
`define PSC_PT2_LSB        3
`define PSC_PT3_LSB        6
`define PSC_PT_RESET       16'h0090

// Power type codes
`define PSC_PT_ACTIVE      3'h0
`define PSC_PT_APPARENT    3'h2
`define PSC_PT_FUND_ACT    3'h3
`define PSC_PT_FUND_REACT  3'h4

// Voltage pairing codes
`define PSC_PAIR_OWN       2'h0
`define PSC_PAIR_NEXT      2'h1
`define PSC_PAIR_PREV      2'h2
`define PSC_PAIR_RSV       2'h3

// Data widths and timing
`define PSC_PWR_W          24
`define PSC_SUM_W          26
`define PSC_SMP_W          24
`define PSC_CLK_HZ         25000000
`define PSC_SOFTWARE_RESET_TRIGGER_NS       640
`define PSC_SOFTWARE_RESET_TRIGGER_CYC      ((`PSC_SOFTWARE_RESET_TRIGGER_NS * (`PSC_CLK_HZ / 1000000) + 999) / 1000)
`define PSC_CNT_W          8

`endif

// ==== design/psc_pkg.sv ====
`include "psc_params.svh"

package psc_pkg;

  typedef logic signed [`PSC_PWR_W-1:0] psc_pwr_t;
  typedef logic signed [`PSC_SUM_W-1:0] psc_sum_t;
  typedef logic signed [`PSC_SMP_W-1:0] psc_smp_t;

  // Per-phase powers from the computation datapath
  typedef struct packed {
    psc_pwr_t active;
    psc_pwr_t fund_active;
    psc_pwr_t fund_react;
    psc_pwr_t apparent;
  } psc_phase_pwr_t;

  // Three-phase ADC sample bundle
  typedef struct packed {
    psc_smp_t ph_c;
    psc_smp_t ph_b;
    psc_smp_t ph_a;
  } psc_samples_t;

  // Decoded configuration outputs
  typedef struct packed {
    logic       phase_integrator_enable;
    logic       neutral_integrator_enable;
    logic       shared_pin_two_select;
    logic       fast_capture_port_enable;
    logic       software_reset_trigger;
    logic [1:0] phase_a_voltage_pairing;
    logic [1:0] phase_b_voltage_pairing;
  } psc_ctrl_t;

endpackage

// ==== design/psc_regs.sv ====
// Chosen here: the APB interface to the registers.
`include "psc_params.svh"

// Overview of operation
// RQ1 - Bit 0: selected phase A active negative
// RQ2 - Bit 1: selected phase B active negative
// RQ3 - Bit 2: selected phase C active negative
// RQ4 - Bit 3: pulse path one sum negative
// RQ5 - Bits 4-6: fundamental reactive negative per phase
// RQ6 - Bit 7: pulse path two sum negative
// RQ7 - Bit 8: pulse path three sum negative
// RQ8 - Sign bits 15:9 always read zero
// RQ9 - Config bit 0 enables phase integrators
// RQ10 - Neutral integrator only by its own bit
// RQ11 - Software keeps config bit 1 at one
// RQ12 - Config bit 2 selects shared pin two
// RQ13 - Config bit 3 swaps voltage and current
// RQ14 - Config bit 4 grounds voltage converters
// RQ15 - Config bit 5 grounds current converters
// RQ16 - Config bit 6 enables fast capture port
// RQ17 - Writing config bit 7 starts software reset
// RQ18 - Bits 9:8 pair voltage with phase A
// RQ19 - Bits 11:10 pair voltage with phase B
// RQ20 - Software reset bit clears when done
// RQ21 - Signs refresh continuously, writes ignored
module psc_regs
  import psc_pkg::*;
(
  input  wire logic                  clock_i,         // 25 MHz core clock
  input  wire logic                  rst_i,           // Sync reset, active high
  input  wire logic                  psel_i,          // APB select
  input  wire logic                  penable_i,       // APB enable
  input  wire logic                  pwrite_i,        // APB write
  input  wire logic [`PSC_ADDR_W-1:0] paddr_i,        // APB byte address
  input  wire logic [31:0]           pwdata_i,        // APB write data
  input  wire logic [3:0]            pstrb_i,         // APB byte strobes
  output logic      [31:0]           prdata_o,        // APB read data
  output logic                       pready_o,        // APB ready
  output logic                       pslverr_o,       // APB error
  input  wire psc_phase_pwr_t        pwr_a_i,         // Phase A powers
  input  wire psc_phase_pwr_t        pwr_b_i,         // Phase B powers
  input  wire psc_phase_pwr_t        pwr_c_i,         // Phase C powers
  input  wire psc_samples_t          volt_adc_i,      // Raw voltage samples
  input  wire psc_samples_t          curr_adc_i,      // Raw current samples
  output psc_samples_t               volt_chan_o,     // Voltage channel data
  output psc_samples_t               curr_chan_o,     // Current channel data
  input  wire logic                  pulse_two_i,     // Pulse output two
  input  wire logic                  harmonic_rdy_i,  // Harmonic ready
  input  wire logic                  pulse_three_i,   // Pulse output three
  input  wire logic                  fast_clk_i,      // Fast capture clock
  output logic                       shared_pin2_o,   // Shared pin two level
  output logic                       shared_pin3_o,   // Shared pin three level
  output psc_ctrl_t                  ctrl_o           // Decoded controls
);

  ////////////////////////////////////////////////////////////////////////////

  localparam logic [`PSC_CNT_W-1:0] SwrstCyc = `PSC_CNT_W'(`PSC_SOFTWARE_RESET_TRIGGER_CYC);

  logic [15:0]           cfg_q;
  logic [15:0]           src_q;
  logic [15:0]           ptype_q;
  logic [15:0]           sign_q;
  logic [15:0]           sign_d;
  logic [`PSC_CNT_W-1:0] rst_cnt_q;
  logic                  software_reset_trigger_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [15:0]           idx;
  logic                  idx_ok;
  logic                  setup;
  logic                  wr_en;
  logic [15:0]           rd_val;
  logic [15:0]           wmask;
  logic [15:0]           cfg_wr;

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign idx    = paddr_i[`PSC_ADDR_W-1:2];
  assign idx_ok = (paddr_i[1:0] == 2'h0) &&
                  (idx == `PSC_IDX_SIGN || idx == `PSC_IDX_CONFIG ||
                   idx == `PSC_IDX_SOURCE || idx == `PSC_IDX_PTYPE);
  assign setup  = psel_i && !penable_i && !pready_q;
  assign wr_en  = psel_i && penable_i && pready_q && pwrite_i && idx_ok;
  assign wmask  = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign cfg_wr = (cfg_q & ~wmask) | (pwdata_i[15:0] & wmask);

  always_comb begin
    rd_val = 16'h0000;
    unique case (idx)
      `PSC_IDX_SIGN:   rd_val = sign_q;
      `PSC_IDX_CONFIG: rd_val = cfg_q;
      `PSC_IDX_SOURCE: rd_val = src_q;
      `PSC_IDX_PTYPE:  rd_val = ptype_q;
      default:         rd_val = 16'h0000;
    endcase
  end

  // One wait-free access cycle: ready rises in the cycle after setup
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !idx_ok;
      if (setup) begin
        prdata_q <= (!pwrite_i && idx_ok) ? {16'h0000, rd_val} : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register and software reset

  // Soft reset returns config to defaults; trigger bit stays set until done
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg_q <= `PSC_CFG_RESET;
    end else if (software_reset_trigger_q && rst_cnt_q == `PSC_CNT_W'(1)) begin
      cfg_q <= `PSC_CFG_RESET;                                    // [RQ20]
    end else if (wr_en && idx == `PSC_IDX_CONFIG) begin
      cfg_q <= cfg_wr;                                            // [RQ9]
      // Bit 1 kept as written; software holds it at one          // [RQ11]
      if (software_reset_trigger_q) begin
        cfg_q[`PSC_CFG_SOFTWARE_RESET_TRIGGER] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      software_reset_trigger_q   <= 1'b0;
      rst_cnt_q <= '0;
    end else if (!software_reset_trigger_q && wr_en && idx == `PSC_IDX_CONFIG &&
                 cfg_wr[`PSC_CFG_SOFTWARE_RESET_TRIGGER]) begin
      software_reset_trigger_q   <= 1'b1;                                          // [RQ17]
      rst_cnt_q <= SwrstCyc;
    end else if (software_reset_trigger_q) begin
      rst_cnt_q <= rst_cnt_q - `PSC_CNT_W'(1);
      if (rst_cnt_q == `PSC_CNT_W'(1)) begin
        software_reset_trigger_q <= 1'b0;                                          // [RQ20]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Own selection registers

  always_ff @(posedge clock_i) begin
    if (rst_i || (software_reset_trigger_q && rst_cnt_q == `PSC_CNT_W'(1))) begin
      src_q   <= `PSC_SRC_RESET;
      ptype_q <= `PSC_PT_RESET;
    end else if (wr_en && idx == `PSC_IDX_SOURCE) begin
      src_q <= (src_q & ~wmask) | (pwdata_i[15:0] & wmask & 16'h07FF);
    end else if (wr_en && idx == `PSC_IDX_PTYPE) begin
      ptype_q <= (ptype_q & ~wmask) | (pwdata_i[15:0] & wmask & 16'h01FF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sign computation

  function automatic psc_pwr_t pick(input psc_phase_pwr_t p, input logic [2:0] ty);
    psc_pwr_t r;
    r = p.active;
    unique case (ty)
      `PSC_PT_APPARENT:   r = p.apparent;
      `PSC_PT_FUND_ACT:   r = p.fund_active;
      `PSC_PT_FUND_REACT: r = p.fund_react;
      // Reserved type codes fall back to total active
      default:            r = p.active;
    endcase
    return r;
  endfunction

  function automatic logic sum_neg(input logic [2:0] terms, input logic [2:0] ty,
                                   input psc_phase_pwr_t a, input psc_phase_pwr_t b,
                                   input psc_phase_pwr_t c);
    psc_sum_t s;
    s = '0;
    if (terms[0]) s = s + psc_sum_t'(pick(a, ty));
    if (terms[1]) s = s + psc_sum_t'(pick(b, ty));
    if (terms[2]) s = s + psc_sum_t'(pick(c, ty));
    return s[`PSC_SUM_W-1];
  endfunction

  logic                  apsel;
  assign apsel = src_q[`PSC_SRC_APSEL];

  always_comb begin
    sign_d     = 16'h0000;                                        // [RQ8]
    sign_d[0]  = apsel ? pwr_a_i.fund_active[`PSC_PWR_W-1]
                       : pwr_a_i.active[`PSC_PWR_W-1];            // [RQ1]
    sign_d[1]  = apsel ? pwr_b_i.fund_active[`PSC_PWR_W-1]
                       : pwr_b_i.active[`PSC_PWR_W-1];            // [RQ2]
    sign_d[2]  = apsel ? pwr_c_i.fund_active[`PSC_PWR_W-1]
                       : pwr_c_i.active[`PSC_PWR_W-1];            // [RQ3]
    sign_d[3]  = sum_neg(src_q[`PSC_SRC_T1_LSB +: 3], ptype_q[`PSC_PT1_LSB +: 3],
                         pwr_a_i, pwr_b_i, pwr_c_i);              // [RQ4]
    sign_d[4]  = pwr_a_i.fund_react[`PSC_PWR_W-1];                // [RQ5]
    sign_d[5]  = pwr_b_i.fund_react[`PSC_PWR_W-1];                // [RQ5]
    sign_d[6]  = pwr_c_i.fund_react[`PSC_PWR_W-1];                // [RQ5]
    sign_d[7]  = sum_neg(src_q[`PSC_SRC_T2_LSB +: 3], ptype_q[`PSC_PT2_LSB +: 3],
                         pwr_a_i, pwr_b_i, pwr_c_i);              // [RQ6]
    sign_d[8]  = sum_neg(src_q[`PSC_SRC_T3_LSB +: 3], ptype_q[`PSC_PT3_LSB +: 3],
                         pwr_a_i, pwr_b_i, pwr_c_i);              // [RQ7]
  end

  // Refreshed every cycle; bus writes never reach it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sign_q <= 16'h0000;
    end else begin
      sign_q <= sign_d;                                           // [RQ21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel swap and grounding

  psc_samples_t volt_src;
  psc_samples_t curr_src;

  // Grounding acts on the converter, so it precedes the swap
  always_comb begin
    volt_src = cfg_q[`PSC_CFG_VGND] ? '0 : volt_adc_i;            // [RQ14]
    curr_src = cfg_q[`PSC_CFG_IGND] ? '0 : curr_adc_i;            // [RQ15]
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      volt_chan_o <= '0;
      curr_chan_o <= '0;
    end else if (cfg_q[`PSC_CFG_SWAP]) begin
      volt_chan_o <= curr_src;                                    // [RQ13]
      curr_chan_o <= volt_src;                                    // [RQ13]
    end else begin
      volt_chan_o <= volt_src;
      curr_chan_o <= curr_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared pins and decoded controls

  // Pins lag the source by one clock; fine for pulse rates
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      shared_pin2_o <= 1'b0;
      shared_pin3_o <= 1'b0;
    end else begin
      shared_pin2_o <= cfg_q[`PSC_CFG_PIN2] ? harmonic_rdy_i : pulse_two_i;  // [RQ12]
      shared_pin3_o <= cfg_q[`PSC_CFG_FCAP] ? fast_clk_i : pulse_three_i;    // [RQ16]
    end
  end

  function automatic logic [1:0] pair(input logic [1:0] code);
    return (code == `PSC_PAIR_RSV) ? `PSC_PAIR_OWN : code;
  endfunction

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o.phase_integrator_enable   <= cfg_q[`PSC_CFG_PHASE_INTEGRATOR_ENABLE];            // [RQ9]
      ctrl_o.neutral_integrator_enable <= src_q[`PSC_SRC_NINT];             // [RQ10]
      ctrl_o.shared_pin_two_select     <= cfg_q[`PSC_CFG_PIN2];             // [RQ12]
      ctrl_o.fast_capture_port_enable  <= cfg_q[`PSC_CFG_FCAP];             // [RQ16]
      ctrl_o.software_reset_trigger    <= software_reset_trigger_q;                          // [RQ17]
      ctrl_o.phase_a_voltage_pairing   <= pair(cfg_q[`PSC_CFG_VA_LSB +: 2]); // [RQ18]
      ctrl_o.phase_b_voltage_pairing   <= pair(cfg_q[`PSC_CFG_VB_LSB +: 2]); // [RQ19]
    end
  end

endmodule

// ==== sim/psc_regs_properties.sv ====
`include "psc_params.svh"

module psc_regs_properties
  import psc_pkg::*;
(
  input wire logic                   clock_i,        // Clock
  input wire logic                   rst_i,          // Reset
  input wire logic                   psel_i,         // Select
  input wire logic                   penable_i,      // Enable
  input wire logic                   pwrite_i,       // Write
  input wire logic [`PSC_ADDR_W-1:0] paddr_i,        // Address
  input wire logic [31:0]            pwdata_i,       // Write data
  input wire logic [3:0]             pstrb_i,        // Strobes
  input wire logic [31:0]            prdata_o,       // Read data
  input wire logic                   pready_o,       // Ready
  input wire logic                   pulse_two_i,    // Pulse two
  input wire logic                   harmonic_rdy_i, // Harmonic ready
  input wire logic                   pulse_three_i,  // Pulse three
  input wire logic                   fast_clk_i,     // Capture clock
  input wire logic                   shared_pin2_o,  // Pin two
  input wire logic                   shared_pin3_o,  // Pin three
  input wire psc_ctrl_t              ctrl_o          // Controls
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic [7:0] hi_cnt_q;
  logic       cfg_wr;

  assign cfg_wr = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0]
                  && paddr_i == {`PSC_IDX_CONFIG, 2'b00};

  // Counter, since sixteen cycles exceed a plain repetition
  always_ff @(posedge clock_i) begin
    if (rst_i || !ctrl_o.software_reset_trigger)
      hi_cnt_q <= 8'h00;
    else
      hi_cnt_q <= hi_cnt_q + 8'h01;
  end

  sequence cfg_write_s;
    cfg_wr;
  endsequence

  chk_sign_rsv_zero: assert property (psel_i && pready_o && !pwrite_i
    && paddr_i == {`PSC_IDX_SIGN, 2'b00} |-> prdata_o[31:9] == 23'h0) else $error("sign pad");
  chk_integ_follow: assert property (cfg_write_s ##0 !pwdata_i[7]
    && !ctrl_o.software_reset_trigger |-> ##2
    ctrl_o.phase_integrator_enable == $past(pwdata_i[0], 2)) else $error("integrator");
  chk_software_reset_trigger_start: assert property (cfg_write_s ##0 pwdata_i[7]
    |-> ##[1:3] ctrl_o.software_reset_trigger) else $error("soft reset missing");
  chk_software_reset_trigger_len: assert property ($fell(ctrl_o.software_reset_trigger)
    |-> $past(hi_cnt_q) == 8'h0F) else $error("soft reset length");
  chk_pin2_mux: assert property (!$past(rst_i) && !ctrl_o.software_reset_trigger
    |-> shared_pin2_o == (ctrl_o.shared_pin_two_select ? $past(harmonic_rdy_i)
    : $past(pulse_two_i))) else $error("pin two mux");
  chk_pin3_mux: assert property (!$past(rst_i) && !ctrl_o.software_reset_trigger
    |-> shared_pin3_o == (ctrl_o.fast_capture_port_enable ? $past(fast_clk_i)
    : $past(pulse_three_i))) else $error("pin three mux");
  chk_pair_a_code: assert property (ctrl_o.phase_a_voltage_pairing != 2'h3)
    else $error("pairing a");
  chk_pair_b_code: assert property (ctrl_o.phase_b_voltage_pairing != 2'h3)
    else $error("pairing b");
endmodule

// ==== sim/tb.sv ====
`include "psc_params.svh"

module tb
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [17:0] A_SIGN = {`PSC_IDX_SIGN, 2'b00};
  localparam logic [17:0] A_CFG  = {`PSC_IDX_CONFIG, 2'b00};
  localparam logic [17:0] A_SRC  = {`PSC_IDX_SOURCE, 2'b00};
  localparam logic [17:0] A_PT   = {`PSC_IDX_PTYPE, 2'b00};

  logic           clock_i = 1'b0;
  logic           rst_i = 1'b1;
  logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [17:0]    paddr = '0;
  logic [31:0]    pwdata = '0, prdata, rd;
  logic           p2 = 1'b0, hr = 1'b0, p3 = 1'b0, fc = 1'b0, pin2, pin3;
  psc_phase_pwr_t pw [3] = '{default: '0};
  psc_samples_t   va = '0, ia = '0, vo, io, ve, ie;
  psc_ctrl_t      ctrl;
  logic [15:0]    src, pt, cfg, e;
  int             miscompares = 0, n_checks = 0, cyc = 0;

  always #20 clock_i = ~clock_i;

  psc_regs uut (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'h3),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pwr_a_i(pw[0]),
    .pwr_b_i(pw[1]), .pwr_c_i(pw[2]), .volt_adc_i(va), .curr_adc_i(ia), .volt_chan_o(vo),
    .curr_chan_o(io), .pulse_two_i(p2), .harmonic_rdy_i(hr), .pulse_three_i(p3),
    .fast_clk_i(fc), .shared_pin2_o(pin2), .shared_pin3_o(pin3), .ctrl_o(ctrl));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Idle edge at the end keeps two calls from driving in one time step
  task automatic apb(input logic wr, input logic [17:0] a, input logic [15:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 50)
      miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask

  function automatic logic [15:0] exp_sign(input logic [15:0] s, input logic [15:0] t);
    logic [15:0] r;
    psc_sum_t    sum;
    psc_pwr_t    v;
    logic [2:0]  ty;
    r = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      r[i] = s[0] ? pw[i].fund_active[23] : pw[i].active[23];
      r[4+i] = pw[i].fund_react[23];
    end
    for (int j = 0; j < 3; j++) begin
      sum = '0;
      ty = t[3*j +: 3];
      for (int i = 0; i < 3; i++) begin
        v = ty == `PSC_PT_APPARENT ? pw[i].apparent : ty == `PSC_PT_FUND_ACT ?
            pw[i].fund_active : ty == `PSC_PT_FUND_REACT ? pw[i].fund_react : pw[i].active;
        if (s[1+3*j+i])
          sum = sum + v;
      end
      r[j == 0 ? 3 : 6+j] = sum[`PSC_SUM_W-1];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    void'($urandom(89259));
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    apb(1'b0, A_CFG, 16'h0);
    check(rd, `PSC_CFG_RESET);
    for (int it = 0; it < 24; it++) begin
      for (int i = 0; i < 3; i++)
        pw[i] <= it == 0 ? '0 : it == 1 ? {4{24'h800000}} : {$urandom, $urandom, $urandom};
      src = it < 2 ? 16'h03FE : 16'($urandom) & 16'h07FF;
      pt = it < 2 ? 16'h0000 : 16'($urandom) & 16'h01FF;
      apb(1'b1, A_SRC, src);
      apb(1'b1, A_PT, pt);
      apb(1'b1, A_SIGN, 16'hFFFF);
      apb(1'b0, A_SIGN, 16'h0);
      e = exp_sign(src, pt);
      check(rd[2:0], e[2:0]);
      check(rd[8:3], e[8:3]);
      check(rd[31:9], 23'h0);
    end
    for (int k = 0; k < 32; k++) begin
      cfg = 16'h0002 | (16'(k) << 2) | 16'(k[0]) | (16'(k[3:0]) << 8);
      va <= {$urandom, $urandom, 8'($urandom)};
      ia <= {$urandom, $urandom, 8'($urandom)};
      {p2, hr, p3, fc} <= 4'($urandom);
      apb(1'b1, A_CFG, cfg);
      @(posedge clock_i);
      ve = cfg[4] ? '0 : va;
      ie = cfg[5] ? '0 : ia;
      check(vo, cfg[3] ? ie : ve);
      check(io, cfg[3] ? ve : ie);
      check(pin2, cfg[2] ? hr : p2);
      check(pin3, cfg[6] ? fc : p3);
      check({ctrl.phase_integrator_enable, ctrl.neutral_integrator_enable},
            {cfg[0], src[10]});
      check({ctrl.shared_pin_two_select, ctrl.fast_capture_port_enable},
            {cfg[2], cfg[6]});
      check(ctrl.phase_a_voltage_pairing, cfg[9:8] == 2'h3 ? 2'h0 : cfg[9:8]);
      check(ctrl.phase_b_voltage_pairing, cfg[11:10] == 2'h3 ? 2'h0 : cfg[11:10]);
      apb(1'b0, A_CFG, 16'h0);
      check(rd, cfg);
    end
    apb(1'b1, A_CFG, 16'h0083);
    apb(1'b0, A_CFG, 16'h0);
    check({rd[7], ctrl.software_reset_trigger}, 2'b11);
    repeat (20) @(posedge clock_i);
    apb(1'b0, A_CFG, 16'h0);
    check({rd, ctrl.software_reset_trigger}, {16'h0, `PSC_CFG_RESET, 1'b0});
    apb(1'b0, A_SRC, 16'h0);
    check(rd, `PSC_SRC_RESET);
    apb(1'b0, 18'h00100, 16'h0);
    check({err, rd}, {1'b1, 32'h0});
    // Leave a non-default type so the reset below has to restore it
    apb(1'b1, A_PT, 16'h0000);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    apb(1'b0, A_PT, 16'h0);
    check(rd, `PSC_PT_RESET);
    results();
  end
endmodule

bind psc_regs psc_regs_properties chk (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pulse_two_i(pulse_two_i),
  .harmonic_rdy_i(harmonic_rdy_i), .pulse_three_i(pulse_three_i), .fast_clk_i(fast_clk_i),
  .shared_pin2_o(shared_pin2_o), .shared_pin3_o(shared_pin3_o), .ctrl_o(ctrl_o));
